// [core/seq_pkg.sv]
/*
 * Sequencer constants, types and row pattern lookup.
 * Assumes nothing of its users.
 */
package seq_pkg;

    // One column stage selects an even/odd pair
    localparam int COL_STAGES = 640;
    localparam int COL_IDX_W  = 10;
    localparam int ROW_W      = 10;
    localparam int PIX_WIDTH  = 10;

    // Analog control word widths
    localparam int GAIN_W   = 4;
    localparam int OFFSET_W = 7;
    localparam int KNEE_W   = 3;

    // Column strides
    localparam logic [COL_IDX_W:0] STRIDE_FULL = 11'h001;
    localparam logic [COL_IDX_W:0] STRIDE_SUB  = 11'h002;

    // Row groups of four
    localparam int GROUP_LSB = 2;

    // Column readout states
    typedef enum logic [1:0] {
        COL_BLANK = 2'b00,
        COL_LOAD  = 2'b01,
        COL_SHIFT = 2'b10
    } col_state_t;

    // Controller pins, synchronised together
    typedef struct packed {
        logic                 col_sync;
        logic                 row_clock;
        logic                 row_start;
        logic                 column_sub;
        logic                 col_xa;
        logic                 col_xb;
        logic                 row_sub;
        logic                 row_xa;
        logic                 row_xb;
        logic [COL_IDX_W-1:0] col_start;
        logic [COL_IDX_W-1:0] col_stop;
        logic [ROW_W-1:0]     row_first;
        logic [GAIN_W-1:0]    gain;
        logic [OFFSET_W-1:0]  fine;
        logic [OFFSET_W-1:0]  coarse;
        logic [KNEE_W-1:0]    knee;
        logic                 ext_supply;
    } pin_bundle_t;

    // Row offset in a group of four
    function automatic logic [1:0] group_offset(input logic second,
                                                input logic xa,
                                                input logic xb);
        logic [1:0] off;
        off = 2'h0;
        case ({xb, xa, second})
            3'h0:    off = 2'h0;
            3'h1:    off = 2'h1;
            3'h2:    off = 2'h0;
            3'h3:    off = 2'h2;
            3'h4:    off = 2'h1;
            3'h5:    off = 2'h3;
            3'h6:    off = 2'h2;
            default: off = 2'h3;
        endcase
        return off;
    endfunction

endpackage

// [core/pix_link_if.sv]
/*
 * Valid/ready pixel link to the output buffer.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
interface pix_link_if #(parameter int W = 11);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    // Producer drives valid and data, consumer answers with ready
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [core/col_shift_reg.sv]
/*
 * One-hot column shift register: load, then shift by one or two.
 * Assumes same-clock load and step strobes.
 */
`timescale 1ns/100ps
module col_shift_reg
    import seq_pkg::*;
#(
    parameter int STAGES = COL_STAGES,
    parameter int IW     = COL_IDX_W
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Control
    input  wire logic              load,
    input  wire logic [IW-1:0]     start_idx,
    input  wire logic              step,
    input  wire logic              double_step,
    // Stage selects
    output logic      [STAGES-1:0] stage_r
);

    logic [STAGES-1:0] stage_nxt;

    // Load wins over shift
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
        logic from_shift;
        if (i >= 2) begin : g_deep
            assign from_shift = double_step ? stage_r[i-2] : stage_r[i-1];
        end else if (i == 1) begin : g_one
            assign from_shift = double_step ? 1'b0 : stage_r[0];
        end else begin : g_zero
            assign from_shift = 1'b0;
        end
        assign stage_nxt[i] = load ? (start_idx == IW'(i)) :
                              (step ? from_shift : stage_r[i]);
    end

    // State flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= '0;
        end else begin
            stage_r <= stage_nxt;
        end
    end

endmodule

// [core/pix_skid_buffer.sv]
/*
 * Two-entry pixel buffer; a receiver stall loses no word.
 * Assumes one shared clock.
 */
`timescale 1ns/100ps
module pix_skid_buffer #(
    parameter int W = 11
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Filling and draining sides
    pix_link_if.snk   up,
    pix_link_if.src   down
);

    logic         head_v_r;
    logic [W-1:0] head_d_r;
    logic         tail_v_r;
    logic [W-1:0] tail_d_r;
    logic         push;
    logic         pop;

    // Ready from a flop: spare slot free
    assign up.ready   = ~tail_v_r;
    assign down.valid = head_v_r;
    assign down.data  = head_d_r;
    assign push       = up.valid & ~tail_v_r;
    assign pop        = head_v_r & down.ready;

    // Head always holds the oldest word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            head_v_r <= 1'b0;
            head_d_r <= '0;
        end else if (pop) begin
            head_v_r <= tail_v_r | push;
            head_d_r <= tail_v_r ? tail_d_r : up.data;
        end else if (!head_v_r) begin
            head_v_r <= push;
            head_d_r <= up.data;
        end
    end

    // Tail fills when head is stuck
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tail_v_r <= 1'b0;
            tail_d_r <= '0;
        end else if (pop) begin
            tail_v_r <= 1'b0;
        end else if (push && head_v_r) begin
            tail_v_r <= 1'b1;
            tail_d_r <= up.data;
        end
    end

endmodule

// [core/pixel_window_address_sequencer.sv]
/*
 * Readout addressing, pixel interleave, amplifier words and
 * reset-rail settings.
 * Assumes async controller pins, and array buses that answer
 * the stage select in the same cycle.
 */

// Functional notes
// - Stage selects a column pair, steps every second clock.
// - Even and odd buses interleaved into one stream.
// - Column sync high loads one-hot start stage.
// - Shifting starts when column sync falls.
// - No column sub-sampling: one stage per step.
// - Column sub-sampling: two stages per step, XXOOXXOO.
// - Column exchange a: XOXOXOXO.
// - Column exchange b: OXOXOXOX.
// - Both column exchanges: OOXXOOXX.
// - Rows have the same five patterns as columns.
// - No row sub-sampling: one row per row clock.
// - Row sub-sampling: two rows, skip two, XXOOXXOO.
// - Four-bit exponential gain code, seven-bit linear offset code.
// - Fine offset trims odd/even, coarse adds common offset.
// - Multi-slope bits set the secondary reset level.
// - External supply select disconnects the rail generator.
// - After row blanking, one pixel leaves per system clock.
`timescale 1ns/100ps
module pixel_window_address_sequencer
    import seq_pkg::*;
#(
    parameter int STAGES = COL_STAGES,
    parameter int PIX_W  = PIX_WIDTH
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Sync pins from the controller
    input  wire logic                 col_sync,
    input  wire logic                 row_clock,
    input  wire logic                 row_start,
    // Window positions
    input  wire logic [COL_IDX_W-1:0] col_start_stage,
    input  wire logic [COL_IDX_W-1:0] col_stop_stage,
    input  wire logic [ROW_W-1:0]     row_start_addr,
    // Sub-sampling controls
    input  wire logic                 column_sub,
    input  wire logic                 column_pair_exchange_a,
    input  wire logic                 column_pair_exchange_b,
    input  wire logic                 row_sub,
    input  wire logic                 row_pair_exchange_a,
    input  wire logic                 row_pair_exchange_b,
    // Output amplifier controls
    input  wire logic [GAIN_W-1:0]    gain_code,
    input  wire logic [OFFSET_W-1:0]  offset_fine_code,
    input  wire logic [OFFSET_W-1:0]  offset_coarse_code,
    // Reset voltage controls
    input  wire logic [KNEE_W-1:0]    multislope_level_bits,
    input  wire logic                 external_reset_supply_select,
    // Column buses from the array
    input  wire logic [PIX_W-1:0]     bus_even_data,
    input  wire logic [PIX_W-1:0]     bus_odd_data,
    // Pixel stream receiver
    input  wire logic                 pixel_ready,
    // Column addressing
    output logic      [STAGES-1:0]    column_stage_select,
    output logic                      col_switch_a,
    output logic                      col_switch_b,
    output logic      [COL_IDX_W-1:0] column_stage_index,
    // Row addressing
    output logic      [ROW_W-1:0]     row_pointer,
    output logic                      row_active,
    // Readout status
    output logic                      amp_calibrate,
    output logic                      line_done,
    // Pixel stream
    output logic                      pixel_valid,
    output logic      [PIX_W-1:0]     pixel_data,
    output logic                      pixel_odd,
    // Amplifier settings
    output logic      [GAIN_W-1:0]    gain_level,
    output logic      [OFFSET_W-1:0]  offset_fine_level,
    output logic      [OFFSET_W-1:0]  offset_coarse_level,
    // Secondary reset rail
    output logic      [KNEE_W-1:0]    rail_level_select,
    output logic                      reset_generator_connect
);

    // Bus tag above the pixel
    localparam int SW = PIX_W + 1;

    pin_bundle_t pins_w;
    pin_bundle_t pin_meta_r;
    pin_bundle_t pin_r;

    logic                 row_clk_d_r;
    logic                 row_edge;
    logic                 row_load;
    logic                 row_step;

    logic [ROW_W-1:0]     row_pointer_r;
    logic [ROW_W-1:0]     row_pointer_nxt;
    logic [ROW_W-3:0]     row_group_r;
    logic [ROW_W-3:0]     row_group_nxt;
    logic                 row_second_r;
    logic                 row_second_nxt;
    logic                 row_active_r;
    logic [1:0]           row_offset;

    col_state_t           state_r;
    col_state_t           state_nxt;
    logic                 phase_r;
    logic [COL_IDX_W-1:0] col_idx_r;
    logic [PIX_W-1:0]     odd_hold_r;
    logic                 calib_r;
    logic                 line_done_r;
    logic                 col_sw_a_r;
    logic                 col_sw_b_r;
    logic                 gen_connect_r;

    logic                 shifting;
    logic                 push;
    logic                 step;
    logic                 sync_on;
    logic [COL_IDX_W:0]   stride;
    logic [COL_IDX_W:0]   idx_next;
    logic                 window_end;

    pix_link_if #(.W(SW)) in_link ();
    pix_link_if #(.W(SW)) out_link ();

    // One synchroniser for all pins
    assign pins_w = {col_sync, row_clock, row_start,
                     column_sub, column_pair_exchange_a, column_pair_exchange_b,
                     row_sub, row_pair_exchange_a, row_pair_exchange_b,
                     col_start_stage, col_stop_stage, row_start_addr,
                     gain_code, offset_fine_code, offset_coarse_code,
                     multislope_level_bits, external_reset_supply_select};

    // Two flops; words must be quasi-static
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= '0;
            pin_r      <= '0;
        end else begin
            pin_meta_r <= pins_w;
            pin_r      <= pin_meta_r;
        end
    end

    // Row clock edge from the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_clk_d_r <= 1'b0;
        end else begin
            row_clk_d_r <= pin_r.row_clock;
        end
    end

    assign row_edge = pin_r.row_clock & ~row_clk_d_r;
    assign row_load = row_edge & pin_r.row_start;
    assign row_step = row_edge & ~pin_r.row_start & row_active_r;

    // Row pointer: plus one, or under row_sub groups of four, exchange picks offset
    assign row_second_nxt = row_load ? 1'b0 : ~row_second_r;
    assign row_offset = group_offset(row_second_nxt, pin_r.row_xa,
                                     pin_r.row_xb);
    assign row_group_nxt = row_load ? pin_r.row_first[ROW_W-1:GROUP_LSB] :
                           (row_second_r ? row_group_r + 1'b1 : row_group_r);
    assign row_pointer_nxt = pin_r.row_sub ? {row_group_nxt, row_offset} :
                             (row_load ? pin_r.row_first :
                              row_pointer_r + 1'b1);

    // Row state moves on row clock edges
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_pointer_r <= '0;
            row_group_r   <= '0;
            row_second_r  <= 1'b0;
            row_active_r  <= 1'b0;
        end else if (row_load || row_step) begin
            row_pointer_r <= row_pointer_nxt;
            row_group_r   <= row_group_nxt;
            row_second_r  <= row_second_nxt;
            row_active_r  <= 1'b1;
        end
    end

    // Column decode; a buffer stall freezes the shift
    assign sync_on    = pin_r.col_sync;
    assign shifting   = (state_r == COL_SHIFT);
    assign push       = shifting & in_link.ready;
    assign step       = push & phase_r;
    assign stride     = pin_r.column_sub ? STRIDE_SUB : STRIDE_FULL;
    assign idx_next   = {1'b0, col_idx_r} + stride;
    assign window_end = step & (idx_next > {1'b0, pin_r.col_stop});

    // Column state machine
    always_comb begin
        state_nxt = state_r;
        if (sync_on) begin
            state_nxt = COL_LOAD;
        end else begin
            case (state_r)
                COL_BLANK: state_nxt = COL_BLANK;
                COL_LOAD:  state_nxt = COL_SHIFT;
                COL_SHIFT: state_nxt = window_end ? COL_BLANK : COL_SHIFT;
                default:   state_nxt = COL_BLANK;
            endcase
        end
    end

    // State and column index
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= COL_BLANK;
            col_idx_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (sync_on) begin
                col_idx_r <= pin_r.col_start;
            end else if (step) begin
                col_idx_r <= idx_next[COL_IDX_W-1:0];
            end
        end
    end

    // Even word first, odd held for the next cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r    <= 1'b0;
            odd_hold_r <= '0;
        end else if (sync_on) begin
            phase_r <= 1'b0;
        end else if (push) begin
            phase_r <= ~phase_r;
            if (!phase_r) begin
                odd_hold_r <= bus_odd_data;
            end
        end
    end

    // Interleave both buses
    assign in_link.valid = shifting;
    assign in_link.data  = phase_r ? {1'b1, odd_hold_r} :
                                     {1'b0, bus_even_data};

    // Calibration: set beats clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            calib_r     <= 1'b0;
            line_done_r <= 1'b0;
        end else begin
            calib_r     <= row_edge | (calib_r & ~(state_r == COL_LOAD && !sync_on));
            line_done_r <= window_end;
        end
    end

    // Column switches act only when sub-sampling; generator connect is the inverse of the supply pin
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_sw_a_r    <= 1'b0;
            col_sw_b_r    <= 1'b0;
            gen_connect_r <= 1'b1;
        end else begin
            col_sw_a_r    <= pin_r.column_sub & pin_r.col_xa;
            col_sw_b_r    <= pin_r.column_sub & pin_r.col_xb;
            gen_connect_r <= ~pin_r.ext_supply;
        end
    end

    // One-hot stage register
    col_shift_reg #(
        .STAGES (STAGES),
        .IW     (COL_IDX_W)
    ) u_col_shift (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .load        (sync_on),
        .start_idx   (pin_r.col_start),
        .step        (step),
        .double_step (pin_r.column_sub),
        .stage_r     (column_stage_select)
    );

    // Buffer absorbs stalls
    pix_skid_buffer #(
        .W (SW)
    ) u_out_buf (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .up      (in_link.snk),
        .down    (out_link.src)
    );

    assign out_link.ready = pixel_ready;

    // Outputs, all straight from flops
    assign pixel_valid         = out_link.valid;
    assign pixel_data          = out_link.data[PIX_W-1:0];
    assign pixel_odd           = out_link.data[PIX_W];
    assign col_switch_a        = col_sw_a_r;
    assign col_switch_b        = col_sw_b_r;
    assign column_stage_index  = col_idx_r;
    assign row_pointer         = row_pointer_r;
    assign row_active          = row_active_r;
    assign amp_calibrate       = calib_r;
    assign line_done           = line_done_r;
    assign gain_level          = pin_r.gain;
    assign offset_fine_level   = pin_r.fine;
    assign offset_coarse_level = pin_r.coarse;
    assign rail_level_select   = pin_r.knee;
    assign reset_generator_connect = gen_connect_r;

endmodule

// [dv/seq_asserts.sv]
/*
 * Port checker: load, stride, pairing, rows.
 * Assumes one clock and a two-stage pin sync.
 */
`timescale 1ns/100ps
module seq_asserts
    import seq_pkg::*;
#(
    parameter int STAGES = COL_STAGES,
    parameter int PIX_W  = PIX_WIDTH
) (
    // Clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    // Controller pins
    input wire logic                 col_sync,
    input wire logic                 row_start,
    input wire logic [COL_IDX_W-1:0] col_start_stage,
    input wire logic                 column_sub,
    input wire logic                 column_pair_exchange_a,
    input wire logic                 column_pair_exchange_b,
    input wire logic                 row_sub,
    input wire logic                 pixel_ready,
    // Addressing and stream outputs
    input wire logic [STAGES-1:0]    column_stage_select,
    input wire logic                 col_switch_a,
    input wire logic                 col_switch_b,
    input wire logic [COL_IDX_W-1:0] column_stage_index,
    input wire logic [ROW_W-1:0]     row_pointer,
    input wire logic                 pixel_valid,
    input wire logic [PIX_W-1:0]     pixel_data,
    input wire logic                 pixel_odd
);
    // Runs of four or five cover the pin sync
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    start_load_a: assert property ((col_sync && $stable(col_start_stage))[*4]
        |-> column_stage_select[col_start_stage] && column_stage_index == col_start_stage)
        else $error("start stage not loaded");
    single_stage_a: assert property ($onehot0(column_stage_select))
        else $error("stages not one-hot");
    step_size_a: assert property ((!col_sync && $stable(column_sub))[*4]
        ##0 $changed(column_stage_index)
        |-> column_stage_index == $past(column_stage_index) + (column_sub ? 10'h002 : 10'h001))
        else $error("wrong stage stride");
    half_rate_a: assert property ((!col_sync)[*4] ##0 $changed(column_stage_index)
        |=> $stable(column_stage_index)) else $error("stage moved twice");
    exch_drive_a: assert property (
        $stable({column_sub, column_pair_exchange_a, column_pair_exchange_b})[*5]
        |-> col_switch_a == (column_sub && column_pair_exchange_a)
            && col_switch_b == (column_sub && column_pair_exchange_b))
        else $error("bad switch drive");
    pair_order_a: assert property (pixel_valid && pixel_ready && !pixel_odd
        |=> pixel_valid && pixel_odd) else $error("odd word missing");
    hold_stall_a: assert property (pixel_valid && !pixel_ready
        |=> pixel_valid && $stable(pixel_data) && $stable(pixel_odd))
        else $error("word lost during stall");
    row_step_a: assert property ((!row_sub && !row_start)[*5] ##0 $changed(row_pointer)
        |-> row_pointer == $past(row_pointer) + 10'h001) else $error("row step not one");

    // Main scenarios reached
    stall_c: cover property (pixel_valid && !pixel_ready);
    sub_step_c: cover property (column_sub && $changed(column_stage_index));
    row_sub_c: cover property (row_sub && $changed(row_pointer));
endmodule

bind pixel_window_address_sequencer seq_asserts #(.STAGES(STAGES), .PIX_W(PIX_W)) u_chk (.*);

// [dv/cam_ctrl_model.sv]
/*
 * Controller and array stand-in: pins by task, buses from the stage.
 * Assumes tasks run from one process.
 */
`timescale 1ns/100ps
module cam_ctrl_model
    import seq_pkg::*;
(
    // Clock and array side
    input  wire logic                 sys_clk,
    input  wire logic [COL_IDX_W-1:0] column_stage_index,
    output logic      [PIX_WIDTH-1:0] bus_even_data,
    output logic      [PIX_WIDTH-1:0] bus_odd_data,
    // Controller pins
    output logic                      col_sync,
    output logic                      row_clock,
    output logic                      row_start,
    output logic      [COL_IDX_W-1:0] col_start_stage,
    output logic      [COL_IDX_W-1:0] col_stop_stage,
    output logic      [ROW_W-1:0]     row_start_addr
);
    // Bus word names its column
    assign bus_even_data = {column_stage_index[8:0], 1'b0};
    assign bus_odd_data  = {column_stage_index[8:0], 1'b1};

    // Pins idle low from time zero
    initial begin
        {col_sync, row_clock, row_start} = 3'h0;
        {col_start_stage, col_stop_stage, row_start_addr} = '0;
    end

    // One row clock, four high, four low
    task automatic row_clk(input logic load, input logic [ROW_W-1:0] addr);
        @(posedge sys_clk);
        #1;
        row_start = load;
        row_start_addr = addr;
        row_clock = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        row_clock = 1'b0;
        row_start = 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // Sync held six cycles, then released
    task automatic col_line(input logic [COL_IDX_W-1:0] first, last);
        @(posedge sys_clk);
        #1;
        col_start_stage = first;
        col_stop_stage = last;
        col_sync = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        col_sync = 1'b0;
    endtask
endmodule

// [dv/testbench.sv]
/*
 * Bench: settings, rows and column lines.
 * Assumes the model answers buses from the stage index.
 */
`timescale 1ns/100ps
module testbench
    import seq_pkg::*;
;
    logic                  sys_clk, rst_n, pixel_ready, col_sync, row_clock, row_start;
    logic                  column_sub, column_pair_exchange_a, column_pair_exchange_b;
    logic                  row_sub, row_pair_exchange_a, row_pair_exchange_b;
    logic                  external_reset_supply_select, reset_generator_connect, row_active;
    logic                  col_switch_a, col_switch_b, amp_calibrate, line_done;
    logic                  pixel_valid, pixel_odd;
    logic [COL_IDX_W-1:0]  col_start_stage, col_stop_stage, column_stage_index;
    logic [ROW_W-1:0]      row_start_addr, row_pointer;
    logic [GAIN_W-1:0]     gain_code, gain_level;
    logic [OFFSET_W-1:0]   offset_fine_code, offset_coarse_code;
    logic [OFFSET_W-1:0]   offset_fine_level, offset_coarse_level;
    logic [KNEE_W-1:0]     multislope_level_bits, rail_level_select;
    logic [PIX_WIDTH-1:0]  bus_even_data, bus_odd_data, pixel_data;
    logic [COL_STAGES-1:0] column_stage_select;
    logic [PIX_WIDTH:0]    got[$];
    logic [1:0]            offs[4][2] = '{'{2'h0, 2'h1}, '{2'h0, 2'h2}, '{2'h1, 2'h3}, '{2'h2, 2'h3}};
    int                    failures, n_tests, cycles, done_seen;

    pixel_window_address_sequencer DUT (.*);
    cam_ctrl_model ctl (.*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Sink and cycle ceiling
    always @(posedge sys_clk) begin
        if (pixel_valid === 1'b1 && pixel_ready === 1'b1)
            got.push_back({pixel_odd, pixel_data});
        if (line_done === 1'b1)
            done_seen++;
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, want);
        n_tests++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic conclude();
        $display("tests %0d fails %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_settings(input logic [3:0] g, input logic [6:0] f, input logic [6:0] c,
                              input logic [2:0] k, input logic e);
        @(posedge sys_clk);
        #1;
        {gain_code, offset_fine_code, offset_coarse_code} = {g, f, c};
        {multislope_level_bits, external_reset_supply_select} = {k, e};
        repeat (6) @(posedge sys_clk);
        check("gain", 16'(gain_level), 16'(g));
        check("fine", 16'(offset_fine_level), 16'(f));
        check("coarse", 16'(offset_coarse_level), 16'(c));
        check("knee", 16'(rail_level_select), 16'(k));
        check("connect", 16'(reset_generator_connect), 16'(!e));
        $display("settings gain %h done", g);
    endtask

    // Rows: plain steps of one, sub-sampled group base plus offset
    task automatic t_rows(input logic [2:0] mode, input logic [9:0] addr);
        logic [9:0] want;
        @(posedge sys_clk);
        #1;
        {row_pair_exchange_b, row_pair_exchange_a, row_sub} = mode;
        ctl.row_clk(1'b1, addr);
        check("calibrate", 16'(amp_calibrate), 16'h1);
        check("active", 16'(row_active), 16'h1);
        for (int k = 0; k < 4; k++) begin
            want = mode[0] ? {addr[9:2] + 8'(k / 2), offs[mode[2:1]][k % 2]} : addr + 10'(k);
            check("row", 16'(row_pointer), 16'(want));
            ctl.row_clk(1'b0, addr);
        end
        $display("rows mode %0d done", mode);
    endtask

    // One line; a stall past the buffer loses nothing
    task automatic t_line(input logic [2:0] mode, input logic [9:0] first, last,
                          input int stall);
        int s;
        logic [9:0] st;
        ctl.row_clk(1'b0, row_start_addr);
        #1;
        {column_pair_exchange_b, column_pair_exchange_a, column_sub} = mode;
        s = mode[0] ? 2 : 1;
        pixel_ready = (stall == 0);
        got.delete();
        done_seen = 0;
        ctl.col_line(first, last);
        repeat (stall) @(posedge sys_clk);
        #1;
        pixel_ready = 1'b1;
        for (int n = 0; n < 500 && done_seen == 0; n++)
            @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
        check("words", 16'(got.size()), 16'(2 * ((last - first) / s + 1)));
        for (int n = 0; n < got.size(); n++) begin
            st = first + 10'(n / 2 * s);
            check("word", 16'(got[n]), 16'({n[0], st[8:0], n[0]}));
        end
        check("switch", 16'({col_switch_b, col_switch_a}), 16'(mode[0] ? mode[2:1] : 2'h0));
        check("done", 16'(done_seen), 16'h1);
        $display("line mode %0d done", mode);
    endtask

    initial begin
        rst_n = 1'b0;
        pixel_ready = 1'b1;
        {column_sub, column_pair_exchange_a, column_pair_exchange_b, row_sub} = '0;
        {row_pair_exchange_a, row_pair_exchange_b, external_reset_supply_select} = '0;
        {gain_code, offset_fine_code, offset_coarse_code, multislope_level_bits} = '0;
        repeat (20) @(posedge sys_clk);
        check("reset connect", 16'(reset_generator_connect), 16'h1);
        #1;
        rst_n = 1'b1;
        t_settings(4'hf, 7'h7f, 7'h00, 3'h5, 1'b1);
        t_settings(4'h0, 7'h00, 7'h7f, 3'h2, 1'b0);
        t_rows(3'h0, 10'h007);
        t_rows(3'h1, 10'h3f8);
        t_rows(3'h3, 10'h004);
        t_rows(3'h5, 10'h008);
        t_rows(3'h7, 10'h00c);
        t_line(3'h0, 10'h005, 10'h00c, 0);
        t_line(3'h1, 10'h276, 10'h27f, 12);
        t_line(3'h3, 10'h000, 10'h008, 0);
        t_line(3'h5, 10'h002, 10'h009, 0);
        t_line(3'h7, 10'h004, 10'h00b, 0);
        conclude();
    end
endmodule
